// ---- src/irq_ctrl_top.sv ----
// Two-level vectored interrupt controller with AHB-Lite register slave
//
// Operation
// - Trigger bit selects edge; polarity selects level
// - External lines observe selected pin passively
// - Edge pending cleared when CPU vectors
// - Level pending mirrors active input level
// - Per-source priority bit, reset low
// - High preempts low; high never preempted
// - Higher level first, then lower index
// - Vectors 0x0003 plus eight times order
// - Sample and resolve requests every cycle
// - Minimum latency five clocks
// - One instruction after return before call
// - Worst latency eighteen clocks
// - Equal or higher active blocks new requests
// - Hardware clears edge-mode externals and timers 0/1
// - Global enable gates every source
// - Base enable bits five to zero
// - Base enable bit six plain flag
// - Extended registers hold six peripheral bits
// - Pending set regardless of enables
// - Software setting pending raises request except on level-mode external lines
// - Pending after return raises new request
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_defines.svh"

module irq_ctrl_top
	import irq_ctrl_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Port pins watched by external lines
	input  wire logic [7:0]  portPins,
	// Flags of timers and peripherals (order 1,3..11 used)
	input  wire logic        timer0_overflow_flag,
	input  wire logic        timer1_overflow_flag,
	input  wire logic [9:0]  periphPending,
	// Core handshake
	input  wire logic        instrDone,
	input  wire logic        retiDone,
	output logic [15:0]      vectorAddr,
	output logic             vectorCall,
	output logic             vectorHigh
);

	//**********************************************************
	// Register storage
	//**********************************************************
	logic [7:0]  irq_enable_mask_ff;
	logic [5:0]  priority_reg_base_ff;
	logic [5:0]  enable_reg_ext_ff;
	logic [5:0]  priority_reg_ext_ff;
	logic [7:0]  ext_line_config_reg_ff;
	logic [1:0]  trigger_type_ff;
	logic [1:0]  timerFlag_ff;
	logic        wrPend_ff;
	logic [7:0]  wrAddr_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] nxt_hrdata;

	//**********************************************************
	// Sequencer state
	//**********************************************************
	seq_state_t  state_ff;
	seq_state_t  nxt_state;
	logic [1:0]  callCnt_ff;
	logic        inLow_ff;
	logic        inHigh_ff;
	logic        lowSaved_ff;
	logic [15:0] vectorAddr_ff;
	logic        vectorCall_ff;
	logic        vectorHigh_ff;
	logic [3:0]  callSrc_ff;

	wire logic        addrPhase = hsel & hready & htrans[1];
	wire logic        doWrite   = wrPend_ff;
	wire logic [7:0]  wb        = hwdata[7:0];

	// Address decode for writes in the data phase
	wire logic wrIe   = doWrite && (wrAddr_ff == `OFS_ENABLE_MASK);
	wire logic wrIp   = doWrite && (wrAddr_ff == `OFS_PRIORITY_BASE);
	wire logic wrEie  = doWrite && (wrAddr_ff == `OFS_ENABLE_EXT);
	wire logic wrEip  = doWrite && (wrAddr_ff == `OFS_PRIORITY_EXT);
	wire logic wrCfg  = doWrite && (wrAddr_ff == `OFS_EXT_CONFIG);
	wire logic wrTrig = doWrite && (wrAddr_ff == `OFS_TRIGGER_TYPE);
	wire logic wrSw   = doWrite && (wrAddr_ff == `OFS_SW_TRIGGER);

	// Software trigger writes one per source bit
	wire logic [11:0] swSet = wrSw ? hwdata[11:0] : 12'h000;

	//**********************************************************
	// External lines and pending vector
	//**********************************************************
	logic [1:0]  extPending;
	logic        ackExt0;
	logic        ackExt1;
	logic        ackTmr0;
	logic        ackTmr1;
	logic        canTake;
	logic        found;
	logic        foundHigh;
	logic [3:0]  winner;
	wire  logic  callFire = (state_ff == SEQ_RUN) && canTake && instrDone;

	wire ext_cfg_t cfg0 = '{polarity: ext_line_config_reg_ff[`BIT_EXT0_POL],
		trigger: trigger_type_ff[0], pinSel: ext_line_config_reg_ff[2:0]};
	wire ext_cfg_t cfg1 = '{polarity: ext_line_config_reg_ff[`BIT_EXT1_POL],
		trigger: trigger_type_ff[1], pinSel: ext_line_config_reg_ff[6:4]};

	// Hardware clears on vectoring for edge-mode externals and timers 0/1
	assign ackExt0 = callFire && (winner == 4'(`SRC_EXT0));
	assign ackTmr0 = callFire && (winner == 4'(`SRC_TIMER0));
	assign ackExt1 = callFire && (winner == 4'(`SRC_EXT1));
	assign ackTmr1 = callFire && (winner == 4'(`SRC_TIMER1));

	ext_line_sense u_ext0 (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.portPins (portPins),
		.cfg      (cfg0),
		.ackClear (ackExt0),
		.swSet    (swSet[`SRC_EXT0]),
		.pending  (extPending[0])
	);

	ext_line_sense u_ext1 (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.portPins (portPins),
		.cfg      (cfg1),
		.ackClear (ackExt1),
		.swSet    (swSet[`SRC_EXT1]),
		.pending  (extPending[1])
	);

	// Timer flags held here; a new overflow beats the vector clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			timerFlag_ff <= 2'h0;
		else
			timerFlag_ff <= {timer1_overflow_flag | swSet[`SRC_TIMER1] | (timerFlag_ff[1] & ~ackTmr1),
				timer0_overflow_flag | swSet[`SRC_TIMER0] | (timerFlag_ff[0] & ~ackTmr0)};
	end

	// Pending in order 0..11; peripheral flags not cleared here
	wire logic [11:0] pending = {periphPending[9:2] | swSet[11:4],
		timerFlag_ff[1], extPending[1], timerFlag_ff[0], extPending[0]};

	// Enable and priority per source
	wire logic [11:0] srcEnable = {enable_reg_ext_ff, irq_enable_mask_ff[5:0]};
	wire logic [11:0] srcHigh   = {priority_reg_ext_ff, priority_reg_base_ff};

	// Global enable gates all; bit six ignored
	wire logic [11:0] request = irq_enable_mask_ff[`BIT_GLOBAL_EN] ?
		(pending & srcEnable) : 12'h000;

	// Resolved combinationally every clock
	irq_arbiter u_arb (
		.request   (request),
		.highPrio  (srcHigh),
		.found     (found),
		.foundHigh (foundHigh),
		.winner    (winner)
	);

	// High preempts low, nothing preempts high
	assign canTake = found && !inHigh_ff && (foundHigh || !inLow_ff);

	//**********************************************************
	// Vector call sequencer
	//**********************************************************
	// Call lasts four cycles after detection
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SEQ_RUN: begin
				if (callFire)
					nxt_state = SEQ_CALL;
				else if (retiDone && (inLow_ff || inHigh_ff))
					nxt_state = SEQ_AFTER;
			end
			SEQ_CALL: begin
				if (callCnt_ff == 2'h3)
					nxt_state = SEQ_RUN;
			end
			SEQ_AFTER: begin
				// One instruction after return before a new call
				if (instrDone)
					nxt_state = SEQ_RUN;
			end
			default: nxt_state = SEQ_RUN;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff   <= SEQ_RUN;
			callCnt_ff <= 2'h0;
		end else begin
			state_ff   <= nxt_state;
			callCnt_ff <= (state_ff == SEQ_CALL) ? callCnt_ff + 2'h1 : 2'h0;
		end
	end

	// Active level tracking; return pops the highest active level
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			inLow_ff    <= 1'b0;
			inHigh_ff   <= 1'b0;
			lowSaved_ff <= 1'b0;
		end else if (callFire) begin
			inHigh_ff   <= foundHigh;
			inLow_ff    <= inLow_ff | ~foundHigh;
			lowSaved_ff <= inLow_ff;
		end else if (state_ff == SEQ_RUN && retiDone) begin
			if (inHigh_ff)
				inHigh_ff <= 1'b0;
			else
				inLow_ff <= 1'b0;
		end
	end

	// Vector outputs; reset vector 0x0000
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			vectorAddr_ff <= `VEC_RESET;
			vectorCall_ff <= 1'b0;
			vectorHigh_ff <= 1'b0;
			callSrc_ff    <= 4'h0;
		end else begin
			vectorCall_ff <= callFire;
			if (callFire) begin
				vectorAddr_ff <= `VEC_BASE + (`VEC_STEP * {12'h000, winner});
				vectorHigh_ff <= foundHigh;
				callSrc_ff    <= winner;
			end
		end
	end

	assign vectorAddr = vectorAddr_ff;
	assign vectorCall = vectorCall_ff;
	assign vectorHigh = vectorHigh_ff;

	//**********************************************************
	// Register file and bus slave
	//**********************************************************
	// Capture address phase, write happens next cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 8'h00;
			hrdata_ff <= 32'h0;
		end else begin
			wrPend_ff <= addrPhase & hwrite;
			wrAddr_ff <= haddr[7:0];
			hrdata_ff <= (addrPhase & ~hwrite) ? nxt_hrdata : hrdata_ff;
		end
	end

	// Register writes; priority bits reset low
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_enable_mask_ff     <= `RST_ENABLE_MASK;
			priority_reg_base_ff   <= 6'(`RST_PRIORITY);
			enable_reg_ext_ff      <= 6'h00;
			priority_reg_ext_ff    <= 6'(`RST_PRIORITY);
			ext_line_config_reg_ff <= `RST_EXT_CONFIG;
			trigger_type_ff        <= `RST_TRIGGER_TYPE;
		end else begin
			if (wrIe)
				irq_enable_mask_ff <= wb;
			if (wrIp)
				priority_reg_base_ff <= wb[5:0];
			if (wrEie)
				enable_reg_ext_ff <= wb[5:0];
			if (wrEip)
				priority_reg_ext_ff <= wb[5:0];
			if (wrCfg)
				ext_line_config_reg_ff <= wb;
			if (wrTrig)
				trigger_type_ff <= wb[1:0];
		end
	end

	// Read mux; unmapped reads zero
	wire logic [7:0] ra = haddr[7:0];
	always_comb begin
		if (ra == `OFS_ENABLE_MASK)
			nxt_hrdata = {24'h0, irq_enable_mask_ff};
		else if (ra == `OFS_PRIORITY_BASE)
			nxt_hrdata = {24'h0, `ALWAYS_ONE_BASE | {2'b00, priority_reg_base_ff}};
		else if (ra == `OFS_ENABLE_EXT)
			nxt_hrdata = {24'h0, 2'b00, enable_reg_ext_ff};
		else if (ra == `OFS_PRIORITY_EXT)
			nxt_hrdata = {24'h0, `ALWAYS_ONE_EXT | {2'b00, priority_reg_ext_ff}};
		else if (ra == `OFS_EXT_CONFIG)
			nxt_hrdata = {24'h0, ext_line_config_reg_ff};
		else if (ra == `OFS_TRIGGER_TYPE)
			nxt_hrdata = {30'h0, trigger_type_ff};
		else if (ra == `OFS_PENDING)
			nxt_hrdata = {20'h0, pending};
		else if (ra == `OFS_SEQ_STATUS)
			nxt_hrdata = {22'h0, callSrc_ff, state_ff, inHigh_ff, inLow_ff, 2'h0};
		else
			nxt_hrdata = 32'h0;
	end

	assign hrdata    = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	//**********************************************************
	// Checks
	//**********************************************************
	AST_GLOBAL_GATE: assert property (@(posedge sys_clk) disable iff (rst)
		!irq_enable_mask_ff[7] |-> !callFire) else $error("call with global enable off");
	AST_HIGH_NOT_PREEMPTED: assert property (@(posedge sys_clk) disable iff (rst)
		inHigh_ff |-> !callFire) else $error("high routine preempted");
	AST_VECTOR_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
		callFire |=> vectorAddr == 16'h0003 + {9'h0, $past(winner), 3'h0})
		else $error("wrong vector");
	AST_CALL_LEN: assert property (@(posedge sys_clk) disable iff (rst)
		callFire |=> (state_ff == SEQ_CALL) [*4] ##1 (state_ff == SEQ_RUN))
		else $error("call not four cycles");
	AST_ONE_AFTER: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == SEQ_AFTER) |-> !callFire) else $error("call before next instruction");
	AST_HIGH_FIRST: assert property (@(posedge sys_clk) disable iff (rst)
		(callFire && |(request & srcHigh)) |-> srcHigh[winner]) else $error("low beat high");
	AST_EDGE_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
		(ackExt0 && trigger_type_ff[0] && !u_ext0.rise && !swSet[0]) |=> !extPending[0])
		else $error("edge flag not cleared");
	AST_TMR_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
		(ackTmr0 && !timer0_overflow_flag && !swSet[1]) |=> !timerFlag_ff[0])
		else $error("timer flag not cleared");
	AST_LOW_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
		(inLow_ff && !foundHigh) |-> !callFire) else $error("equal level preempted");

endmodule : irq_ctrl_top
`default_nettype wire

// ---- inc/irq_ctrl_defines.svh ----
// Offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH

// Register byte addresses
`define OFS_ENABLE_MASK    8'ha8
`define OFS_PRIORITY_BASE  8'hb8
`define OFS_ENABLE_EXT     8'he6
`define OFS_PRIORITY_EXT   8'hf6
`define OFS_EXT_CONFIG     8'he4
`define OFS_PENDING        8'h00
`define OFS_SEQ_STATUS     8'h04
`define OFS_SW_TRIGGER     8'h08
`define OFS_TRIGGER_TYPE   8'h0c

// Reset values
`define RST_ENABLE_MASK    8'h00
`define RST_PRIORITY       8'h00
`define RST_EXT_CONFIG     8'h01
`define RST_TRIGGER_TYPE   2'h0

// Field positions
`define BIT_GLOBAL_EN      7
`define BIT_SPARE_FLAG     6
`define BIT_EXT0_POL       3
`define BIT_EXT1_POL       7
`define ALWAYS_ONE_BASE    8'hc0
`define ALWAYS_ONE_EXT     8'hc0

// Source order indices
`define SRC_EXT0           0
`define SRC_TIMER0         1
`define SRC_EXT1           2
`define SRC_TIMER1         3
`define NUM_SRC            12

// Vectors
`define VEC_RESET          16'h0000
`define VEC_BASE           16'h0003
`define VEC_STEP           16'h0008

// Timing in system clock cycles
`define DETECT_CYCLES      3'h1
`define CALL_CYCLES        3'h4
`define RETI_CYCLES        3'h5
`define DIV_CYCLES         4'h8
`define MIN_LATENCY        5
`define MAX_LATENCY        18

`endif

// ---- inc/irq_ctrl_pkg.sv ----
// Types shared by the interrupt controller modules
package irq_ctrl_pkg;

	// Sequencer states
	typedef enum logic [1:0] {
		SEQ_RUN   = 2'b00,
		SEQ_CALL  = 2'b01,
		SEQ_AFTER = 2'b10
	} seq_state_t;

	// One vector call toward the core
	typedef struct packed {
		logic        valid;
		logic [3:0]  source;
		logic        high;
		logic [15:0] addr;
	} vector_call_t;

	// Per external line configuration
	typedef struct packed {
		logic       polarity;
		logic       trigger;
		logic [2:0] pinSel;
	} ext_cfg_t;

endpackage : irq_ctrl_pkg

// ---- src/ext_line_sense.sv ----
// External interrupt line: pin select, sync, polarity, edge or level detect
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_defines.svh"

module ext_line_sense
	import irq_ctrl_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [7:0] portPins,
	input  wire ext_cfg_t   cfg,
	input  wire logic       ackClear,
	input  wire logic       swSet,
	output logic            pending
);

	logic syncA_ff;
	logic syncB_ff;
	logic prev_ff;
	logic edgeFlag_ff;
	logic nxt_edgeFlag;
	logic active;
	logic rise;

	// Pin is only observed, never driven
	wire logic selPin = portPins[cfg.pinSel];

	// Two-stage synchroniser before polarity and edge logic
	// Reset to the idle level of an active-low line so no false edge follows reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			syncA_ff <= 1'b1;
			syncB_ff <= 1'b1;
			prev_ff  <= 1'b0;
		end else begin
			syncA_ff <= selPin;
			syncB_ff <= syncA_ff;
			prev_ff  <= active;
		end
	end

	// Polarity 0 active low, 1 active high
	assign active = cfg.polarity ? syncB_ff : ~syncB_ff;
	assign rise   = active & ~prev_ff;

	// Edge flag: set wins over hardware clear on vectoring
	// Held clear in level mode so a stale edge cannot surface on a mode change
	assign nxt_edgeFlag = cfg.trigger & (rise | swSet | (edgeFlag_ff & ~ackClear));

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			edgeFlag_ff <= 1'b0;
		else
			edgeFlag_ff <= nxt_edgeFlag;
	end

	// Trigger 1 edge, 0 level follows input
	assign pending = cfg.trigger ? edgeFlag_ff : active;

endmodule : ext_line_sense
`default_nettype wire

// ---- src/irq_arbiter.sv ----
// Fixed-order two-level priority resolver over twelve sources
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_defines.svh"

module irq_arbiter
	import irq_ctrl_pkg::*;
(
	input  wire logic [11:0] request,
	input  wire logic [11:0] highPrio,
	output logic             found,
	output logic             foundHigh,
	output logic [3:0]       winner
);

	// Lowest index set bit
	function automatic logic [3:0] firstSet(input logic [11:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 11; i >= 0; i--) begin
			if (v[i])
				idx = 4'(i);
		end
		return idx;
	endfunction : firstSet

	wire logic [11:0] hiReq = request & highPrio;
	wire logic [11:0] loReq = request & ~highPrio;

	// High level first, then fixed order
	assign found     = |request;
	assign foundHigh = |hiReq;
	assign winner    = (|hiReq) ? firstSet(hiReq) : firstSet(loReq);

endmodule : irq_arbiter
`default_nettype wire

// ---- tb/core_model.sv ----
// Behavioural CPU sequencer that answers vector calls and returns
`timescale 1ns/100ps
`default_nettype none

module core_model (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic vectorCall,
	input  wire logic stall,
	input  wire logic doReti,
	output logic      instrDone,
	output logic      retiDone
);
	logic [2:0] callCnt_ff;
	logic [2:0] retiCnt_ff;

	// Four busy cycles after a vector call, five for a return
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			callCnt_ff <= 3'h0;
			retiCnt_ff <= 3'h0;
		end else begin
			callCnt_ff <= vectorCall ? 3'h4 : callCnt_ff - {2'h0, callCnt_ff != 3'h0};
			retiCnt_ff <= doReti ? 3'h5 : retiCnt_ff - {2'h0, retiCnt_ff != 3'h0};
		end
	end

	// Instructions retire only outside calls and returns; stall makes a slow core
	assign instrDone = (callCnt_ff == 3'h0) && (retiCnt_ff == 3'h0) && !vectorCall && !stall;
	assign retiDone  = (retiCnt_ff == 3'h1);
endmodule : core_model
`default_nettype wire

// ---- tb/two_level_vectored_irq_ctrl_test.sv ----
// Self-checking bench of the interrupt controller
`timescale 1ns/100ps
`default_nettype none

module two_level_vectored_irq_ctrl_test;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  portPins = 8'hff;
	logic        t0Flag = 1'b0;
	logic        t1Flag = 1'b0;
	logic [9:0]  periphPending = 10'h0;
	logic        instrDone;
	logic        retiDone;
	logic [15:0] vectorAddr;
	logic        vectorCall;
	logic        vectorHigh;
	logic        stall = 1'b0;
	logic        slow = 1'b0;
	logic        noise = 1'b0;
	logic        doReti = 1'b0;
	logic [31:0] rd;
	int          seed = 4054;
	int          err_total = 0;
	int          samples_checked = 0;
	int          cyc;

	// Clock of 5 ns
	always #2.5 sys_clk = ~sys_clk;

	// Random core stalls and noise on pins that no line watches
	always @(posedge sys_clk) begin
		stall <= slow && ($random(seed) & 1);
		if (noise) portPins[7:3] <= 5'($random(seed));
	end

	irq_ctrl_top i_dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.portPins(portPins), .timer0_overflow_flag(t0Flag), .timer1_overflow_flag(t1Flag),
		.periphPending(periphPending), .instrDone(instrDone), .retiDone(retiDone),
		.vectorAddr(vectorAddr), .vectorCall(vectorCall), .vectorHigh(vectorHigh));

	core_model i_core (.sys_clk(sys_clk), .rst(rst), .vectorCall(vectorCall), .stall(stall),
		.doReti(doReti), .instrDone(instrDone), .retiDone(retiDone));

	// Verdict and end of run
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	// Compare one value and count it
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One AHB-Lite single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	// Read a register and compare the masked value
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask : rchk

	// Wait for a vector call, counting cycles, then compare it
	task automatic waitCall(input logic [15:0] ea, input logic eh);
		cyc = 0;
		#1;
		while (vectorCall !== 1'b1 && cyc < 60) begin
			@(posedge sys_clk);
			#1;
			cyc++;
		end
		chk(vectorCall, 1'b1);
		chk(vectorAddr, ea);
		chk(vectorHigh, eh);
	endtask : waitCall

	// No vector call for n cycles
	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			chk(vectorCall, 1'b0);
		end
	endtask : quiet

	// Core executes a return
	task automatic reti();
		doReti <= 1'b1;
		@(posedge sys_clk);
		doReti <= 1'b0;
	endtask : reti

	// Raise source n by timer pulse, peripheral level or software trigger
	task automatic raise(input int n);
		if (n == 1 || n == 3) begin
			t0Flag <= (n == 1);
			t1Flag <= (n == 3);
			@(posedge sys_clk);
			t0Flag <= 1'b0;
			t1Flag <= 1'b0;
		end else if (n >= 4 && n % 2 == 0) begin
			periphPending[n-2] <= 1'b1;
		end else begin
			bus(1'b1, 8'h08, 32'h1 << n);
		end
	endtask : raise

	// Watchdog against a hang
	initial begin
		#200000;
		err_total++;
		give_verdict();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		rchk(8'ha8, 32'hff, 32'h00);
		rchk(8'hb8, 32'hff, 32'hc0);
		rchk(8'hf6, 32'hff, 32'hc0);
		rchk(8'he6, 32'hff, 32'h00);
		rchk(8'he4, 32'hff, 32'h01);
		rchk(8'h40, 32'hffffffff, 32'h0);
		chk(vectorAddr, 16'h0000);
		// Global enable off: flag sets but no call
		bus(1'b1, 8'ha8, 32'h7f);
		rchk(8'ha8, 32'hff, 32'h7f);
		raise(1);
		quiet(20);
		rchk(8'h00, 32'h2, 32'h2);
		bus(1'b1, 8'ha8, 32'hc2);
		waitCall(16'h000b, 1'b0);
		reti();
		quiet(10);
		// Every source vectors to its address; one-cycle software requests need a ready core
		bus(1'b1, 8'ha8, 32'hbf);
		bus(1'b1, 8'he6, 32'h3f);
		bus(1'b1, 8'h0c, 32'h3);
		for (int n = 0; n < 12; n++) begin
			slow <= (n == 1 || n == 3);
			raise(n);
			waitCall(16'h0003 + 16'(8 * n), 1'b0);
			if (n >= 4 && n % 2 == 0) chk(cyc <= 5, 1'b1);
			bus(1'b0, 8'h00, 32'h0);
			if (n < 4 || n % 2 == 0) chk(rd[n], n >= 4);
			periphPending <= 10'h0;
			reti();
			quiet(12);
		end
		slow <= 1'b0;
		// Priority, preemption and return order
		bus(1'b1, 8'hf6, 32'h20);
		periphPending <= 10'h208;
		waitCall(16'h005b, 1'b1);
		raise(1);
		quiet(15);
		periphPending <= 10'h008;
		reti();
		waitCall(16'h000b, 1'b0);
		chk(cyc >= 6, 1'b1);
		quiet(15);
		periphPending <= 10'h208;
		waitCall(16'h005b, 1'b1);
		periphPending <= 10'h008;
		reti();
		quiet(15);
		reti();
		waitCall(16'h002b, 1'b0);
		periphPending <= 10'h000;
		reti();
		quiet(12);
		// External lines: configure in level mode, then switch line 0 to edge once settled
		bus(1'b1, 8'ha8, 32'h00);
		bus(1'b1, 8'h0c, 32'h0);
		bus(1'b1, 8'he4, 32'h0a);
		portPins[2] <= 1'b0;
		noise <= 1'b1;
		repeat (4) @(posedge sys_clk);
		bus(1'b1, 8'h0c, 32'h1);
		rchk(8'h00, 32'h5, 32'h0);
		portPins[2] <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rchk(8'h00, 32'h5, 32'h1);
		portPins[0] <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rchk(8'h00, 32'h5, 32'h5);
		portPins[0] <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rchk(8'h00, 32'h5, 32'h1);
		bus(1'b1, 8'ha8, 32'h81);
		waitCall(16'h0003, 1'b0);
		rchk(8'h00, 32'h1, 32'h0);
		reti();
		bus(1'b1, 8'ha8, 32'h84);
		portPins[0] <= 1'b0;
		waitCall(16'h0013, 1'b0);
		portPins[0] <= 1'b1;
		reti();
		quiet(15);
		give_verdict();
	end
endmodule : two_level_vectored_irq_ctrl_test
`default_nettype wire
